// ==== hdl/rbd_params.svh ====
// rbd_params.svh: offsets, field positions and reset values of the row decoder
// assumes: included by bare name from hdl/ files only
`ifndef RBD_PARAMS_SVH
`define RBD_PARAMS_SVH

// row header byte offsets from the even row base
`define RBD_OFF_MODE 4'h0
`define RBD_OFF_COUNT 4'h2
`define RBD_OFF_ATTR 4'h4
`define RBD_OFF_RANGE 4'h5
`define RBD_OFF_FIRST_CHAR 4'h6
// per-mode offset of the first byte of character z, counted from base + stride * z
`define RBD_SER_OFF 4'h5
`define RBD_BAS_OFF 4'h4
`define RBD_EXT_OFF 4'h3
// bytes per character
`define RBD_STRIDE_SER 2'h1
`define RBD_STRIDE_BAS 2'h2
`define RBD_STRIDE_EXT 2'h3
// last fetch step per group
`define RBD_LAST_HDR 2'h3
`define RBD_LAST_SER 2'h0
`define RBD_LAST_BAS 2'h1
`define RBD_LAST_EXT 2'h2
// serial positions shown as border
`define RBD_SER_BORDER_POS 6'h02
// palette byte addresses of entry 0
`define RBD_FORE_PAL_BASIC 8'h10
`define RBD_BACK_PAL_BASIC 8'h30
`define RBD_FORE_PAL_EXT 8'h50
`define RBD_BACK_PAL_EXT 8'h70
// header fields
`define RBD_MODE_MSB 7
`define RBD_MODE_LSB 6
`define RBD_RCN_MSB 7
`define RBD_RCN_LSB 2
`define RBD_ATTR_FM 7
`define RBD_ATTR_FON 2
`define RBD_ATTR_FR 0
`define RBD_RS_MSB 7
`define RBD_RS_LSB 4
`define RBD_RE_MSB 3
`define RBD_RE_LSB 0
// serial byte fields
`define RBD_SER_ATTR 7
`define RBD_SER_BACK 6
`define RBD_SER_FLASH 5
`define RBD_SER_ITAL 4
// shape byte fields
`define RBD_SHP_CODE_EXTENSION 7
`define RBD_SHP_SPL_MSB 6
`define RBD_SHP_SPL_LSB 5
`define RBD_SHP_FXP 4
`define RBD_SHP_BXP 3
`define RBD_SHP_FOC 2
`define RBD_SHP_SHA 1
`define RBD_SHP_FRC 0
// reset value of the serial pointers and saturation limit of the line counter
`define RBD_PTR_RESET 4'h0
`define RBD_LINE_MAX 7'h7F

`endif

// ==== hdl/rbd_pkg.sv ====
// rbd_pkg: types shared by the row decoder files
// assumes: compiled before the modules
package rbd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_WAIT = 6'h04,
    ST_CAPT = 6'h08,
    ST_DEC = 6'h10,
    ST_EMIT = 6'h20
  } rbd_state_t;
  typedef enum logic [1:0] {
    MODE_SERIAL = 2'h0,
    MODE_BASIC = 2'h1,
    MODE_EXT = 2'h2,
    MODE_RSVD = 2'h3
  } rbd_mode_t;
endpackage

// ==== hdl/rbd_pal_addr.sv ====
// rbd_pal_addr: palette pointer to palette byte address
// assumes: purely combinational, registered by the instantiating module
`timescale 1ns/1ps
`default_nettype none
module rbd_pal_addr #(
  parameter logic [7:0] BASIC_BASE = 8'h10,
  parameter logic [7:0] EXT_BASE = 8'h50
)
(
  // pointer and bank selection
  input wire logic [3:0] i_ptr,
  input wire logic i_ext_sel,
  input wire logic i_swap,
  // byte address of the first byte of the entry
  output logic [7:0] o_addr
);
  // two bytes per entry; swap inverts the per-character bank choice
  assign o_addr = ((i_swap ^ i_ext_sel) ? EXT_BASE : BASIC_BASE) + {3'h0, i_ptr, 1'b0};
endmodule // rbd_pal_addr
`default_nettype wire

// ==== hdl/rbd_row_decoder.sv ====
// rbd_row_decoder: fetches row header and character bytes from display ram
// per tv line and hands decoded characters to the pixel pipeline
// assumes: synchronous ram with read data one cycle after o_ram_rd,
// strobes come from logic on i_ref_clk
// What this block does
// - row fringe bit gates fringe on all characters
// - outside start/end line range show border
// - large font matrix counts lines in pairs
// - serial bit7 code/attribute, bit6 fore/back
// - serial code low seven bits index font
// - serial first two positions show border
// - serial attributes shown as background space
// - serial byte z fetched at base+5+z
// - back pointer selects entry, zero at 30h
// - foreground flash bit flags following characters
// - italic bit until row end or next foreground
// - fore pointer selects entry, zero at 10h
// - basic code at base+4+2z, palette after
// - palette byte: fore upper, back lower nibble
// - extended code, palette, shape at base+3+3z
// - shape layout depends on font matrix
// - shape bits extend code: three or one
// - small matrix index: extension, split, code
// - row mode from top header bits
// - row shows row character count characters
// - row flash on blanks flagged characters
`timescale 1ns/1ps
`default_nettype none
`include "rbd_params.svh"
module rbd_row_decoder
  import rbd_pkg::*;
#(
  parameter int AW = 9,
  parameter int CW = 6,
  parameter int IW = 11,
  parameter int LW = 7
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // timing strobes and configuration
  input wire logic i_row_start,
  input wire logic i_line_start,
  input wire logic [AW-1:0] i_row_base,
  input wire logic i_palette_swap,
  // display ram read port
  output logic o_ram_rd,
  output logic [AW-1:0] o_ram_addr,
  input wire logic [7:0] i_ram_rdata,
  // character stream
  output logic o_char_valid,
  input wire logic i_char_ready,
  output logic [IW-1:0] o_char_index,
  output logic [7:0] o_fore_pal_addr,
  output logic [7:0] o_back_pal_addr,
  output logic o_border,
  output logic o_space,
  output logic o_flash,
  output logic o_italic,
  output logic o_fringe,
  output logic o_shadow,
  output logic o_char_last,
  // status
  output logic o_line_busy
);
  rbd_state_t state_q;
  rbd_mode_t mode_q;
  logic hdr_q;
  logic [1:0] step_q;
  logic [CW-1:0] z_q;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] base_q;
  logic [CW-1:0] rcn_q;
  logic fr_q;
  logic fon_q;
  logic fm_q;
  logic [3:0] rs_q;
  logic [3:0] re_q;
  logic [7:0] b0_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [LW-1:0] line_cnt_q;
  logic first_q;
  logic pair_q;
  logic [3:0] ser_fp_q;
  logic [3:0] ser_bp_q;
  logic ser_flash_q;
  logic ser_ital_q;
  logic [1:0] last_step;
  logic [1:0] stride;
  logic [AW-1:0] addr_d;
  logic in_range;
  logic [IW-1:0] idx_d;
  logic [3:0] fp_d;
  logic [3:0] bp_d;
  logic fx_d;
  logic bx_d;
  logic space_d;
  logic border_d;
  logic flash_d;
  logic ital_d;
  logic fringe_d;
  logic shadow_d;
  logic [3:0] ser_fp_d;
  logic [3:0] ser_bp_d;
  logic ser_flash_d;
  logic ser_ital_d;
  logic [7:0] fore_addr_d;
  logic [7:0] back_addr_d;

  // fetch geometry per mode; reserved mode walks like serial and shows border
  always_comb
  begin
    case (mode_q)
      MODE_BASIC:
      begin
        last_step = `RBD_LAST_BAS;
        stride = `RBD_STRIDE_BAS;
      end
      MODE_EXT:
      begin
        last_step = `RBD_LAST_EXT;
        stride = `RBD_STRIDE_EXT;
      end
      default:
      begin
        last_step = `RBD_LAST_SER;
        stride = `RBD_STRIDE_SER;
      end
    endcase
    if (hdr_q)
    begin
      last_step = `RBD_LAST_HDR;
    end
  end

  // header bytes first, then bytes of the current character
  always_comb
  begin
    if (hdr_q)
    begin
      case (step_q)
        2'h0: addr_d = base_q + AW'(`RBD_OFF_MODE);
        2'h1: addr_d = base_q + AW'(`RBD_OFF_COUNT);
        2'h2: addr_d = base_q + AW'(`RBD_OFF_ATTR);
        default: addr_d = base_q + AW'(`RBD_OFF_RANGE);
      endcase
    end
    else
    begin
      addr_d = ptr_q + AW'(step_q);
    end
  end

  // sequencer; a new line start aborts any unfinished walk
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_q <= ST_IDLE;
      hdr_q <= 1'b0;
      step_q <= 2'h0;
      z_q <= '0;
      ptr_q <= '0;
      base_q <= '0;
    end
    else if (i_line_start)
    begin
      state_q <= ST_ADDR;
      hdr_q <= 1'b1;
      step_q <= 2'h0;
      z_q <= '0;
      base_q <= {i_row_base[AW-1:1], 1'b0};
    end
    else
    begin
      case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ADDR: state_q <= ST_WAIT;
        ST_WAIT: state_q <= ST_CAPT;
        ST_CAPT:
        begin
          if (step_q != last_step)
          begin
            step_q <= step_q + 2'h1;
            state_q <= ST_ADDR;
          end
          else if (hdr_q)
          begin
            hdr_q <= 1'b0;
            step_q <= 2'h0;
            z_q <= CW'(1);
            ptr_q <= base_q + AW'(`RBD_OFF_FIRST_CHAR);
            state_q <= (rcn_q == '0) ? ST_IDLE : ST_ADDR;
          end
          else
          begin
            state_q <= ST_DEC;
          end
        end
        ST_DEC: state_q <= ST_EMIT;
        ST_EMIT:
        begin
          if (i_char_ready)
          begin
            if (z_q == rcn_q)
            begin
              state_q <= ST_IDLE;
            end
            else
            begin
              z_q <= z_q + CW'(1);
              ptr_q <= ptr_q + AW'(stride);
              step_q <= 2'h0;
              state_q <= ST_ADDR;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ram port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_ram_rd <= 1'b0;
      o_ram_addr <= '0;
    end
    else
    begin
      o_ram_rd <= (state_q == ST_ADDR) && !i_line_start;
      if (state_q == ST_ADDR)
      begin
        o_ram_addr <= addr_d;
      end
    end
  end

  // row header capture
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      mode_q <= MODE_SERIAL;
      rcn_q <= '0;
      fr_q <= 1'b0;
      fon_q <= 1'b0;
      fm_q <= 1'b0;
      rs_q <= 4'h0;
      re_q <= 4'h0;
    end
    else if (state_q == ST_CAPT && hdr_q && !i_line_start)
    begin
      case (step_q)
        2'h0: mode_q <= rbd_mode_t'(i_ram_rdata[`RBD_MODE_MSB:`RBD_MODE_LSB]);
        2'h1: rcn_q <= i_ram_rdata[`RBD_RCN_MSB:`RBD_RCN_LSB];
        2'h2:
        begin
          fm_q <= i_ram_rdata[`RBD_ATTR_FM];
          fon_q <= i_ram_rdata[`RBD_ATTR_FON];
          fr_q <= i_ram_rdata[`RBD_ATTR_FR];
        end
        default:
        begin
          rs_q <= i_ram_rdata[`RBD_RS_MSB:`RBD_RS_LSB];
          re_q <= i_ram_rdata[`RBD_RE_MSB:`RBD_RE_LSB];
        end
      endcase
    end
  end

  // character byte capture
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end
    else if (state_q == ST_CAPT && !hdr_q)
    begin
      case (step_q)
        2'h0: b0_q <= i_ram_rdata;
        2'h1: b1_q <= i_ram_rdata;
        default: b2_q <= i_ram_rdata;
      endcase
    end
  end

  // row line counter; font matrix is the one of the previous line header
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_row_start)
    begin
      line_cnt_q <= '0;
      first_q <= 1'b1;
      pair_q <= 1'b0;
    end
    else if (i_line_start)
    begin
      if (first_q)
      begin
        first_q <= 1'b0;
      end
      else if (fm_q && !pair_q)
      begin
        pair_q <= 1'b1;
      end
      else
      begin
        pair_q <= 1'b0;
        if (line_cnt_q != `RBD_LINE_MAX)
        begin
          line_cnt_q <= line_cnt_q + LW'(1);
        end
      end
    end
  end

  assign in_range = (LW'(rs_q) <= line_cnt_q) && (line_cnt_q < LW'(re_q));

  // character decode
  always_comb
  begin
    ser_fp_d = ser_fp_q;
    ser_bp_d = ser_bp_q;
    ser_flash_d = ser_flash_q;
    ser_ital_d = ser_ital_q;
    idx_d = '0;
    fp_d = 4'h0;
    bp_d = 4'h0;
    fx_d = 1'b0;
    bx_d = 1'b0;
    space_d = 1'b0;
    border_d = !in_range;
    flash_d = 1'b0;
    ital_d = 1'b0;
    fringe_d = fr_q;
    shadow_d = 1'b0;
    case (mode_q)
      MODE_SERIAL:
      begin
        if (b0_q[`RBD_SER_ATTR])
        begin
          if (b0_q[`RBD_SER_BACK])
          begin
            ser_bp_d = b0_q[3:0];
          end
          else
          begin
            ser_fp_d = b0_q[3:0];
            ser_flash_d = b0_q[`RBD_SER_FLASH];
            ser_ital_d = b0_q[`RBD_SER_ITAL];
          end
          space_d = 1'b1;
        end
        else
        begin
          idx_d = IW'(b0_q[6:0]);
          flash_d = ser_flash_q;
        end
        fp_d = ser_fp_d;
        bp_d = ser_bp_d;
        ital_d = ser_ital_d;
        if (z_q <= `RBD_SER_BORDER_POS)
        begin
          border_d = 1'b1;
        end
      end
      MODE_BASIC:
      begin
        idx_d = IW'(b0_q);
        fp_d = b1_q[7:4];
        bp_d = b1_q[3:0];
      end
      MODE_EXT:
      begin
        fp_d = b1_q[7:4];
        bp_d = b1_q[3:0];
        fx_d = b2_q[`RBD_SHP_FXP];
        bx_d = b2_q[`RBD_SHP_BXP];
        flash_d = b2_q[`RBD_SHP_FOC];
        shadow_d = b2_q[`RBD_SHP_SHA];
        fringe_d = fr_q && b2_q[`RBD_SHP_FRC];
        if (fm_q)
        begin
          idx_d = IW'({b2_q[`RBD_SHP_CODE_EXTENSION], b0_q});
        end
        else
        begin
          idx_d = IW'({b2_q[`RBD_SHP_CODE_EXTENSION], b2_q[`RBD_SHP_SPL_MSB:`RBD_SHP_SPL_LSB], b0_q});
        end
      end
      default: border_d = 1'b1;
    endcase
    if (fon_q && flash_d)
    begin
      space_d = 1'b1;
    end
  end

  rbd_pal_addr #(
    .BASIC_BASE(`RBD_FORE_PAL_BASIC),
    .EXT_BASE(`RBD_FORE_PAL_EXT)
  ) u_fore_pal (
    .i_ptr(fp_d),
    .i_ext_sel(fx_d),
    .i_swap(i_palette_swap),
    .o_addr(fore_addr_d)
  );

  rbd_pal_addr #(
    .BASIC_BASE(`RBD_BACK_PAL_BASIC),
    .EXT_BASE(`RBD_BACK_PAL_EXT)
  ) u_back_pal (
    .i_ptr(bp_d),
    .i_ext_sel(bx_d),
    .i_swap(i_palette_swap),
    .o_addr(back_addr_d)
  );

  // serial attribute state lives for one line; every line rereads the buffer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_line_start)
    begin
      ser_fp_q <= `RBD_PTR_RESET;
      ser_bp_q <= `RBD_PTR_RESET;
      ser_flash_q <= 1'b0;
      ser_ital_q <= 1'b0;
    end
    else if (state_q == ST_DEC)
    begin
      ser_fp_q <= ser_fp_d;
      ser_bp_q <= ser_bp_d;
      ser_flash_q <= ser_flash_d;
      ser_ital_q <= ser_ital_d;
    end
  end

  // character output; fields hold until the pipeline takes them
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_char_valid <= 1'b0;
      o_char_index <= '0;
      o_fore_pal_addr <= 8'h00;
      o_back_pal_addr <= 8'h00;
      o_border <= 1'b0;
      o_space <= 1'b0;
      o_flash <= 1'b0;
      o_italic <= 1'b0;
      o_fringe <= 1'b0;
      o_shadow <= 1'b0;
      o_char_last <= 1'b0;
    end
    else if (i_line_start)
    begin
      o_char_valid <= 1'b0;
    end
    else if (state_q == ST_DEC)
    begin
      o_char_valid <= 1'b1;
      o_char_index <= idx_d;
      o_fore_pal_addr <= fore_addr_d;
      o_back_pal_addr <= back_addr_d;
      o_border <= border_d;
      o_space <= space_d;
      o_flash <= flash_d;
      o_italic <= ital_d;
      o_fringe <= fringe_d;
      o_shadow <= shadow_d;
      o_char_last <= (z_q == rcn_q);
    end
    else if (state_q == ST_EMIT && i_char_ready)
    begin
      o_char_valid <= 1'b0;
    end
  end

  // status
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_line_busy <= 1'b0;
    end
    else
    begin
      o_line_busy <= i_line_start || (state_q != ST_IDLE);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  serial_fetch_addr_a: assert property (o_ram_rd && !hdr_q && mode_q == MODE_SERIAL
    |-> o_ram_addr == base_q + AW'(`RBD_SER_OFF) + AW'(z_q))
    else $error("serial fetch address wrong");
  basic_fetch_addr_a: assert property (o_ram_rd && !hdr_q && mode_q == MODE_BASIC
    |-> o_ram_addr == base_q + AW'(`RBD_BAS_OFF) + AW'({z_q, 1'b0}) + AW'(step_q))
    else $error("basic fetch address wrong");
  ext_fetch_addr_a: assert property (o_ram_rd && !hdr_q && mode_q == MODE_EXT
    |-> o_ram_addr == base_q + AW'(`RBD_EXT_OFF) + AW'(z_q) + AW'({z_q, 1'b0}) + AW'(step_q))
    else $error("extended fetch address wrong");
  serial_border_a: assert property ($rose(o_char_valid) && mode_q == MODE_SERIAL
    && z_q <= `RBD_SER_BORDER_POS |-> o_border)
    else $error("serial lead position not border");
  range_border_a: assert property ($rose(o_char_valid)
    && (line_cnt_q < LW'(rs_q) || line_cnt_q >= LW'(re_q)) |-> o_border)
    else $error("line outside range not border");
  serial_index_a: assert property ($rose(o_char_valid) && mode_q == MODE_SERIAL
    |-> o_char_index[IW-1:7] == '0)
    else $error("serial index above 127");
  flash_space_a: assert property ($rose(o_char_valid) && o_flash && fon_q |-> o_space)
    else $error("flashing character not blanked");
  fringe_gate_a: assert property ($rose(o_char_valid) && !fr_q |-> !o_fringe)
    else $error("fringe without row fringe bit");
  held_char_a: assert property (o_char_valid && !i_char_ready && !i_line_start
    |=> o_char_valid && $stable(o_char_index) && $stable(o_border))
    else $error("character dropped before taken");
  pair_count_a: assert property (i_line_start && !i_row_start && !first_q && fm_q && !pair_q
    |=> $stable(line_cnt_q) && pair_q)
    else $error("large matrix line pair not held");
endmodule // rbd_row_decoder
`default_nettype wire

// ==== testbench/rbd_ram_model.sv ====
// rbd_ram_model: display ram as filled by software, one synchronous read port
// assumes: the bench writes mem directly between lines; data is due one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module rbd_ram_model
(
  // clock
  input wire logic i_ref_clk,
  // read port
  input wire logic i_rd,
  input wire logic [8:0] i_addr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:511];
  // outside the answer cycle the bus toggles, so a capture on the wrong edge is caught
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rd)
      o_rdata <= mem[i_addr];
    else
      o_rdata <= ~o_rdata;
  end
endmodule // rbd_ram_model
`default_nettype wire

// ==== testbench/rbd_row_decoder_test.sv ====
// rbd_row_decoder_test: self-checking bench for the row decoder
// assumes: rbd_ram_model stands on the ram port; one row buffer at a fixed base
`timescale 1ns/1ps
`default_nettype none
module rbd_row_decoder_test;
  localparam logic [8:0] BASE = 9'h040;
  logic clk, srst, row_start, line_start, swap, ram_rd, char_valid, char_ready;
  logic [8:0] row_base, ram_addr;
  logic [7:0] ram_rdata, fore, back;
  logic [10:0] idx;
  logic border, space, flash, italic, fringe, shadow, last, busy;
  int mismatches, cmp_count, n_got;
  logic [33:0] g [1:64];

  rbd_row_decoder dut_u (.i_ref_clk(clk), .i_srst(srst), .i_row_start(row_start), .i_line_start(line_start),
    .i_row_base(row_base), .i_palette_swap(swap), .o_ram_rd(ram_rd), .o_ram_addr(ram_addr),
    .i_ram_rdata(ram_rdata), .o_char_valid(char_valid), .i_char_ready(char_ready), .o_char_index(idx),
    .o_fore_pal_addr(fore), .o_back_pal_addr(back), .o_border(border), .o_space(space), .o_flash(flash),
    .o_italic(italic), .o_fringe(fringe), .o_shadow(shadow), .o_char_last(last), .o_line_busy(busy));
  rbd_ram_model ram_u (.i_ref_clk(clk), .i_rd(ram_rd), .i_addr(ram_addr), .o_rdata(ram_rdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // flags: border, space, flash, italic, fringe, shadow, last
  function automatic logic [33:0] w(logic [10:0] i, logic [7:0] f, logic [7:0] b, logic [6:0] fl);
    return {i, f, b, fl};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ec(input int z, input logic [33:0] exp, input logic [33:0] m);
    chk(g[z] & m, exp & m);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hdr(input logic [1:0] mode, input logic [5:0] cnt, input logic [7:0] attr, input logic [7:0] rng);
    ram_u.mem[BASE] = {mode, 6'h00};
    ram_u.mem[BASE+2] = {cnt, 2'h0};
    ram_u.mem[BASE+4] = attr;
    ram_u.mem[BASE+5] = rng;
  endtask

  task automatic new_row(input bit sw);
    @(posedge clk);
    row_start <= 1'b1;
    swap <= sw;
    @(posedge clk);
    row_start <= 1'b0;
  endtask

  // walks one line; with stall the sink is ready one cycle in four, so held fields get compared
  task automatic run_line(input bit stall);
    int t;
    logic [33:0] cur, prev;
    bit held;
    n_got = 0;
    held = 0;
    t = 0;
    @(posedge clk);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    while (busy === 1'b1 && t < 3000)
    begin
      cur = w(idx, fore, back, {border, space, flash, italic, fringe, shadow, last});
      if (held && cur !== prev)
        chk(cur, prev);
      held = char_valid === 1'b1 && char_ready === 1'b0;
      prev = cur;
      if (char_valid === 1'b1 && char_ready === 1'b1)
      begin
        n_got++;
        g[n_got] = cur;
      end
      @(posedge clk);
      char_ready <= !stall || t[1:0] == 2'h3;
      t++;
      @(negedge clk);
    end
    // a line that never goes idle counts as a mismatch
    chk(34'(t < 3000), 34'h1);
  endtask

  task automatic t_basic();
    for (int k = 0; k < 2; k++)
    begin
      hdr(2'h1, 6'h02, k ? 8'h04 : 8'h05, 8'h0D);
      ram_u.mem[BASE+6] = 8'hA5;
      ram_u.mem[BASE+7] = 8'h3C;
      ram_u.mem[BASE+8] = 8'hFF;
      ram_u.mem[BASE+9] = 8'hF0;
      new_row(k[0]);
      run_line(1);
      chk(34'(n_got), 34'd2);
      ec(1, w(11'h0A5, k ? 8'h56 : 8'h16, k ? 8'h88 : 8'h48, {4'h0, !k, 2'h0}), '1);
      ec(2, w(11'h0FF, k ? 8'h6E : 8'h2E, k ? 8'h70 : 8'h30, {4'h0, !k, 2'h1}), '1);
    end
    $display("basic parallel done");
  endtask

  task automatic t_serial();
    logic [7:0] b [1:6];
    b = '{8'h20, 8'h21, 8'h41, 8'hB5, 8'hC7, 8'h7F};
    hdr(2'h0, 6'h06, 8'h04, 8'h0D);
    for (int z = 1; z < 7; z++)
      ram_u.mem[BASE+5+z] = b[z];
    new_row(0);
    run_line(0);
    chk(34'(n_got), 34'd6);
    ec(1, '1, 34'h40);
    ec(2, '1, 34'h40);
    ec(3, w(11'h041, 8'h10, 8'h30, 7'h00), '1);
    ec(4, w(11'h000, 8'h1A, 8'h00, 7'h28), w(11'h000, 8'hFF, 8'h00, 7'h68));
    ec(5, w(11'h000, 8'h1A, 8'h3E, 7'h20), w(11'h000, 8'hFF, 8'hFF, 7'h60));
    ec(6, w(11'h07F, 8'h1A, 8'h3E, 7'h39), '1);
    $display("serial done");
  endtask

  task automatic t_ext();
    for (int fm = 0; fm < 2; fm++)
    begin
      hdr(2'h2, 6'h01, {fm[0], 7'h01}, 8'h0D);
      ram_u.mem[BASE+6] = 8'h34;
      ram_u.mem[BASE+7] = 8'h9A;
      ram_u.mem[BASE+8] = 8'hD7;
      new_row(0);
      run_line(1);
      chk(34'(n_got), 34'd1);
      ec(1, w(fm ? 11'h134 : 11'h634, 8'h62, 8'h44, 7'h17), '1);
    end
    $display("extended parallel done");
  endtask

  // lines 1 and 3 of the large matrix are skipped: where the pair boundary falls is open
  task automatic t_range();
    for (int fm = 0; fm < 2; fm++)
    begin
      hdr(2'h1, 6'h01, {fm[0], 7'h00}, 8'h12);
      new_row(0);
      for (int l = 0; l < 5; l++)
      begin
        run_line(0);
        if (fm == 0 || (l != 1 && l != 3))
          ec(1, 34'(l != (fm ? 2 : 1)) << 6, 34'h40);
      end
    end
    $display("active range done");
  endtask

  task automatic t_long();
    hdr(2'h3, 6'h02, 8'h00, 8'h0D);
    new_row(0);
    run_line(0);
    chk(34'(n_got), 34'd2);
    ec(1, '1, 34'h40);
    ec(2, '1, 34'h40);
    hdr(2'h1, 6'h3F, 8'h00, 8'h0D);
    for (int z = 1; z < 64; z++)
      ram_u.mem[BASE+4+2*z] = 8'(z);
    new_row(0);
    run_line(1);
    chk(34'(n_got), 34'd63);
    ec(62, w(11'h03E, 8'h00, 8'h00, 7'h00), w(11'h7FF, 8'h00, 8'h00, 7'h01));
    ec(63, w(11'h03F, 8'h00, 8'h00, 7'h01), w(11'h7FF, 8'h00, 8'h00, 7'h01));
    $display("reserved mode and full row done");
  endtask

  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    srst = 1'b1;
    row_start = 1'b0;
    line_start = 1'b0;
    row_base = BASE;
    swap = 1'b0;
    char_ready = 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(34'({char_valid, ram_rd, busy, idx}), 34'h0);
    $display("reset done");
    t_basic();
    t_serial();
    t_ext();
    t_range();
    t_long();
    test_done();
  end

  // the whole run needs about a thousand cycles
  initial
  begin
    #(8 * 20000);
    mismatches++;
    test_done();
  end
endmodule // rbd_row_decoder_test
`default_nettype wire
